// ===== verilog/tmr3_pkg.sv
/*
  Package for the reload/capture timer: register offsets, bit positions,
  reset values and divider counts.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
`default_nettype none

package tmr3_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W = 5;
  localparam int          DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0]  OFS_CTRL   = 5'h00;
  localparam logic [4:0]  OFS_CNT_L  = 5'h04;
  localparam logic [4:0]  OFS_CNT_H  = 5'h08;
  localparam logic [4:0]  OFS_RLD_L  = 5'h0C;
  localparam logic [4:0]  OFS_RLD_H  = 5'h10;
  localparam logic [4:0]  OFS_CLKCTL = 5'h14;

  // ----------------------------------------------------------------
  // timer_control_reg bit positions
  // ----------------------------------------------------------------
  localparam int          CT_XCLK  = 0;
  localparam int          CT_CSS   = 1;
  localparam int          CT_RUN   = 2;
  localparam int          CT_SPLIT = 3;
  localparam int          CT_CE    = 4;
  localparam int          CT_LIEN  = 5;
  localparam int          CT_LOVF  = 6;
  localparam int          CT_HOVF  = 7;

  // ----------------------------------------------------------------
  // clock_control_reg bit positions
  // ----------------------------------------------------------------
  localparam int          CK_LSEL = 0;
  localparam int          CK_HSEL = 1;
  localparam int          CK_IE   = 2;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [2:0]  RST_CLKCTL = 3'h0;
  localparam logic [7:0]  BYTE_MAX   = 8'hFF;
  localparam logic [3:0]  DIV12_LAST = 4'h0B;
  localparam logic [2:0]  DIV8_LAST  = 3'h7;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : tmr3_pkg

`default_nettype wire

// ===== verilog/tmr3_sync.sv
/*
  Two-flop synchroniser with rising-edge detector.
  Assumes an asynchronous single-bit input; the pulse lasts one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tmr3_sync
  import tmr3_pkg::*;
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // Raw input
  input  wire logic i_async,
  // Synchronised rising edge
  output logic      o_rise
);

  logic meta_r, meta_nxt;
  logic sync_r, sync_nxt;
  logic last_r, last_nxt;

  always_comb
  begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  // One pulse per rising edge
  assign o_rise = sync_r & ~last_r;

endmodule : tmr3_sync

`default_nettype wire

// ===== verilog/tmr3_cnt8.sv
/*
  One 8-bit count byte with software write, reload and wrap detect.
  Assumes the parent supplies increment, reload value and write strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module tmr3_cnt8
  import tmr3_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  // Counting
  input  wire logic       i_inc,
  input  wire logic       i_load,
  input  wire logic [7:0] i_load_val,
  // Software write
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wr_val,
  // State
  output logic [7:0]      o_cnt,
  output logic            o_wrap
);

  logic [7:0] cnt_r, cnt_nxt;

  assign o_wrap = i_inc & (cnt_r == BYTE_MAX);
  assign o_cnt  = cnt_r;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (i_wr)
      cnt_nxt = i_wr_val;
    else if (o_wrap && i_load)
      cnt_nxt = i_load_val;
    else if (i_inc)
      cnt_nxt = cnt_r + 8'h01;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      cnt_r <= RST_BYTE;
    else
      cnt_r <= cnt_nxt;
  end

endmodule : tmr3_cnt8

`default_nettype wire

// ===== verilog/tmr3_top.sv
/*
  Reload/capture timer: two count bytes, reload bytes, prescalers,
  capture triggers and an AXI4-Lite register slave.
  Assumes one clock; triggers and external oscillator are asynchronous.
*/
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module tmr3_top
  import tmr3_pkg::*;
(
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [DATA_W-1:0]      o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Clock and capture sources
  input  wire logic              i_ext_osc,
  input  wire logic              i_usb_sof,
  input  wire logic              i_low_freq_osc,
  // Interrupt request
  output logic                   o_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]        ctrl_r,   ctrl_nxt;
  logic [2:0]        clkctl_r, clkctl_nxt;
  logic [7:0]        rld_l_r,  rld_l_nxt;
  logic [7:0]        rld_h_r,  rld_h_nxt;
  logic [3:0]        d12_r,    d12_nxt;
  logic [2:0]        d8_r,     d8_nxt;
  logic              irq_r,    irq_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [7:0]        wdata_r,  wdata_nxt;
  logic              wstb_r,   wstb_nxt;
  logic              aw_h_r,   aw_h_nxt;
  logic              w_h_r,    w_h_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r,  bresp_nxt;
  logic              arrdy_r,  arrdy_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        rresp_r,  rresp_nxt;
  logic [DATA_W-1:0] rdata_r,  rdata_nxt;
  logic              awrdy_r,  awrdy_nxt;
  logic              wrdy_r,   wrdy_nxt;
  logic              ext_rise, sof_rise, slow_rise;
  logic              d12_tick, ext_tick, lo_tick, hi_tick;
  logic              split, ce, run, lo_inc, hi_inc, lo_wrap, hi_wrap;
  logic              cap, reload_en, do_wr, wr_cl, wr_ch;
  logic [7:0]        cnt_l, cnt_h;
  logic [DATA_W-1:0] rmux;
  logic              rmapped, wmapped;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  tmr3_sync u_ext (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_async(i_ext_osc),
                   .o_rise(ext_rise));
  tmr3_sync u_sof (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_async(i_usb_sof),
                   .o_rise(sof_rise));
  tmr3_sync u_slow (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_async(i_low_freq_osc),
                    .o_rise(slow_rise));

  // ----------------------------------------------------------------
  // Prescalers and clock select
  // ----------------------------------------------------------------
  assign d12_tick = (d12_r == DIV12_LAST);
  assign ext_tick = ext_rise & (d8_r == DIV8_LAST);
  assign lo_tick  = clkctl_r[CK_LSEL] ? 1'b1 :
                    (ctrl_r[CT_XCLK] ? ext_tick : d12_tick);
  assign hi_tick  = clkctl_r[CK_HSEL] ? 1'b1 :
                    (ctrl_r[CT_XCLK] ? ext_tick : d12_tick);
  always_comb
  begin
    d12_nxt = d12_tick ? 4'h0 : d12_r + 4'h1;
    d8_nxt  = ext_rise ? d8_r + 3'h1 : d8_r;
  end

  // ----------------------------------------------------------------
  // Mode decode and count bytes
  // ----------------------------------------------------------------
  assign split     = ctrl_r[CT_SPLIT];
  assign ce        = ctrl_r[CT_CE];
  assign run       = ctrl_r[CT_RUN];
  assign lo_inc    = split ? lo_tick : (run & lo_tick);
  assign hi_inc    = split ? (run & hi_tick) : lo_wrap;
  assign reload_en = ~ce;
  assign cap       = ce & (ctrl_r[CT_CSS] ? slow_rise : sof_rise);
  assign do_wr     = aw_h_r & w_h_r & ~bvalid_r;
  assign wr_cl     = do_wr & wstb_r & (awaddr_r == OFS_CNT_L);
  assign wr_ch     = do_wr & wstb_r & (awaddr_r == OFS_CNT_H);
  // In 16-bit mode the low byte only reloads with the high byte
  tmr3_cnt8 u_lo (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_inc(lo_inc),
                  .i_load(reload_en & (split | hi_wrap)), .i_load_val(rld_l_r),
                  .i_wr(wr_cl), .i_wr_val(wdata_r), .o_cnt(cnt_l),
                  .o_wrap(lo_wrap));
  tmr3_cnt8 u_hi (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_inc(hi_inc),
                  .i_load(reload_en), .i_load_val(rld_h_r),
                  .i_wr(wr_ch), .i_wr_val(wdata_r), .o_cnt(cnt_h),
                  .o_wrap(hi_wrap));

  // ----------------------------------------------------------------
  // Control, reload and flag registers
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    clkctl_nxt = clkctl_r;
    rld_l_nxt  = rld_l_r;
    rld_h_nxt  = rld_h_r;
    if (do_wr && wstb_r)
    begin
      case (awaddr_r)
        OFS_CTRL:   ctrl_nxt   = wdata_r;
        OFS_RLD_L:  rld_l_nxt  = wdata_r;
        OFS_RLD_H:  rld_h_nxt  = wdata_r;
        OFS_CLKCTL: clkctl_nxt = wdata_r[2:0];
        default:    ctrl_nxt   = ctrl_r;
      endcase
    end
    // Capture overrides a software write to the reload bytes
    if (cap)
    begin
      rld_l_nxt = cnt_l;
      rld_h_nxt = cnt_h;
    end
    // Hardware sets win over a same-cycle software clear
    if (hi_wrap || cap)
      ctrl_nxt[CT_HOVF] = 1'b1;
    if (lo_wrap)
      ctrl_nxt[CT_LOVF] = 1'b1;
    irq_nxt = clkctl_nxt[CK_IE] & (ctrl_nxt[CT_HOVF] |
              (ctrl_nxt[CT_LIEN] & ctrl_nxt[CT_LOVF]));
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wmapped = (awaddr_r == OFS_CTRL)  || (awaddr_r == OFS_CNT_L) ||
                   (awaddr_r == OFS_CNT_H) || (awaddr_r == OFS_RLD_L) ||
                   (awaddr_r == OFS_RLD_H) || (awaddr_r == OFS_CLKCTL);
  always_comb
  begin
    rmapped = 1'b1;
    rmux    = 32'h0000_0000;
    case (i_araddr)
      OFS_CTRL:   rmux[7:0] = ctrl_r;
      OFS_CNT_L:  rmux[7:0] = cnt_l;
      OFS_CNT_H:  rmux[7:0] = cnt_h;
      OFS_RLD_L:  rmux[7:0] = rld_l_r;
      OFS_RLD_H:  rmux[7:0] = rld_h_r;
      OFS_CLKCTL: rmux[2:0] = clkctl_r;
      default:    rmapped   = 1'b0;
    endcase
  end
  always_comb
  begin
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstb_nxt   = wstb_r;
    aw_h_nxt   = aw_h_r;
    w_h_nxt    = w_h_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (i_awvalid && awrdy_r)
    begin
      awaddr_nxt = i_awaddr;
      aw_h_nxt   = 1'b1;
    end
    if (i_wvalid && wrdy_r)
    begin
      wdata_nxt = i_wdata[7:0];
      wstb_nxt  = i_wstrb[0];
      w_h_nxt   = 1'b1;
    end
    if (do_wr)
    begin
      aw_h_nxt   = 1'b0;
      w_h_nxt    = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = wmapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_r && i_bready)
      bvalid_nxt = 1'b0;
    if (i_arvalid && arrdy_r)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rmux;
      rresp_nxt  = rmapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && i_rready)
      rvalid_nxt = 1'b0;
    awrdy_nxt = ~aw_h_nxt & ~bvalid_nxt;
    wrdy_nxt  = ~w_h_nxt & ~bvalid_nxt;
    arrdy_nxt = ~rvalid_nxt;
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      ctrl_r   <= RST_BYTE;
      clkctl_r <= RST_CLKCTL;
      rld_l_r  <= RST_BYTE;
      rld_h_r  <= RST_BYTE;
      d12_r    <= 4'h0;
      d8_r     <= 3'h0;
      irq_r    <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= RST_BYTE;
      wstb_r   <= 1'b0;
      aw_h_r   <= 1'b0;
      w_h_r    <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      arrdy_r  <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
      awrdy_r  <= 1'b0;
      wrdy_r   <= 1'b0;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      clkctl_r <= clkctl_nxt;
      rld_l_r  <= rld_l_nxt;
      rld_h_r  <= rld_h_nxt;
      d12_r    <= d12_nxt;
      d8_r     <= d8_nxt;
      irq_r    <= irq_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wstb_r   <= wstb_nxt;
      aw_h_r   <= aw_h_nxt;
      w_h_r    <= w_h_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      arrdy_r  <= arrdy_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
      awrdy_r  <= awrdy_nxt;
      wrdy_r   <= wrdy_nxt;
    end
  end
  assign o_awready = awrdy_r;
  assign o_wready  = wrdy_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_arready = arrdy_r;
  assign o_rvalid  = rvalid_r;
  assign o_rresp   = rresp_r;
  assign o_rdata   = rdata_r;
  assign o_irq     = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  reload16_a: assert property (!split && !ce && lo_inc && cnt_l == 8'hFF && cnt_h == 8'hFF
    && !do_wr |=> cnt_l == $past(rld_l_r) && cnt_h == $past(rld_h_r) && ctrl_r[CT_HOVF])
    else $error("16-bit wrap did not reload");
  split_hold_a: assert property (split && !run && !do_wr |=> cnt_h == $past(cnt_h))
    else $error("High byte moved while stopped");
  split_low_a: assert property (split && !ce && lo_tick && cnt_l != 8'hFF && !do_wr
    |=> cnt_l == $past(cnt_l) + 8'h01)
    else $error("Low byte did not count in split");
  low_flag_a: assert property (lo_wrap |=> ctrl_r[CT_LOVF])
    else $error("Low wrap flag missing");
  flag_keep_a: assert property (ctrl_r[CT_HOVF] && !do_wr |=> ctrl_r[CT_HOVF])
    else $error("High flag cleared by hardware");
  capture_copy_a: assert property (cap |=> rld_l_r == $past(cnt_l) && rld_h_r == $past(cnt_h))
    else $error("Capture did not latch counts");
  capture_hold_a: assert property (ce && !cap && !do_wr |=> $stable(rld_l_r))
    else $error("Reload changed without capture");
  irq_level_a: assert property (clkctl_r[CK_IE] && ctrl_r[CT_HOVF] |-> o_irq)
    else $error("Overflow interrupt missing");
  irq_low_a: assert property (clkctl_r[CK_IE] && ctrl_r[CT_LIEN] && ctrl_r[CT_LOVF] |-> o_irq)
    else $error("Low overflow interrupt missing");
  div12_gap_a: assert property (d12_tick |=> !d12_tick [*8])
    else $error("System/12 tick too soon");
  bhold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("Write response dropped");
  rhold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("Read data dropped");
  cov_reload16_c: cover property (!split && !ce && hi_wrap);
  cov_split_c:    cover property (split && hi_wrap && lo_wrap);
  cov_sof_c:      cover property (cap && !ctrl_r[CT_CSS]);
  cov_slow_c:     cover property (cap && ctrl_r[CT_CSS]);
endmodule : tmr3_top
`default_nettype wire

// ===== verification/tmr3_top_tb.sv
/*
  Self-checking bench for the reload/capture timer: register access, 16-bit and
  split counting, prescalers, flags, interrupt and both capture sources.
  Assumes tmr3_pkg and the design files are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none

module tmr3_top_tb
  import tmr3_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              mclk = 1'b0, nrst = 1'b0, irq;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, rd_v;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, rsp_v;
  logic              ext_osc = 1'b0, usb_sof = 1'b0, slow_osc = 1'b0;
  logic [3:0]        wstrb = 4'h1;
  // Edges the master lets pass before raising bready or rready
  int                n_fail = 0, checks_done = 0, lag = 0;

  tmr3_top dut_u (
    .i_mclk (mclk), .i_nrst (nrst), .i_awaddr (awaddr), .i_awvalid (awvalid),
    .o_awready (awready), .i_wdata (wdata), .i_wstrb (wstrb), .i_wvalid (wvalid),
    .o_wready (wready), .o_bresp (bresp), .o_bvalid (bvalid), .i_bready (bready),
    .i_araddr (araddr), .i_arvalid (arvalid), .o_arready (arready), .o_rdata (rdata),
    .o_rresp (rresp), .o_rvalid (rvalid), .i_rready (rready), .i_ext_osc (ext_osc),
    .i_usb_sof (usb_sof), .i_low_freq_osc (slow_osc), .o_irq (irq)
  );

  always #50 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic chk_irq(input logic e);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : chk_irq

  // Ready and response are looked at on the falling edge, taken on the rising one
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic pa, pw, ta, tw, b;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= (lag == 0);
    pa = 1'b1;
    pw = 1'b1;
    b  = 1'b0;
    while (pa || pw)
    begin
      @(negedge mclk);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    repeat (lag) @(posedge mclk);
    bready <= 1'b1;
    while (!b)
    begin
      @(negedge mclk);
      b     = bvalid;
      rsp_v = bresp;
      @(posedge mclk);
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    logic t;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= (lag == 0);
    t = 1'b0;
    while (!t)
    begin
      @(negedge mclk);
      t = arready;
      @(posedge mclk);
    end
    arvalid <= 1'b0;
    repeat (lag) @(posedge mclk);
    rready  <= 1'b1;
    t = 1'b0;
    while (!t)
    begin
      @(negedge mclk);
      t     = rvalid;
      rd_v  = rdata;
      rsp_v = rresp;
      @(posedge mclk);
    end
    rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask : rdc

  task automatic cfg(input logic [7:0] cl, input logic [7:0] ch, input logic [7:0] rl,
                     input logic [7:0] rh);
    wr(OFS_CNT_L, cl);
    wr(OFS_CNT_H, ch);
    wr(OFS_RLD_L, rl);
    wr(OFS_RLD_H, rh);
  endtask : cfg

  // One rising edge on the chosen trigger, held for six cycles
  task automatic pulse(input logic slow);
    @(posedge mclk);
    if (slow) slow_osc <= 1'b1;
    else usb_sof <= 1'b1;
    repeat (6) @(posedge mclk);
    slow_osc <= 1'b0;
    usb_sof  <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : pulse

  task automatic end_of_test;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [4:0] ofs [6] = '{OFS_CTRL, OFS_CNT_L, OFS_CNT_H, OFS_RLD_L, OFS_RLD_H, OFS_CLKCTL};
    chk_irq(1'b0);
    foreach (ofs[i]) rdc(ofs[i], 32'h0000_0000);
    chk({30'h0, rsp_v}, {30'h0, RESP_OKAY});
    rdc(5'h18, 32'h0000_0000);
    chk({30'h0, rsp_v}, {30'h0, RESP_SLVERR});
    lag = 2;
    wr(5'h18, 8'hFF);
    chk({30'h0, rsp_v}, {30'h0, RESP_SLVERR});
    cfg(8'hA5, 8'h5A, 8'hC3, 8'h3C);
    rdc(OFS_CNT_L, 32'h0000_00A5);
    rdc(OFS_RLD_H, 32'h0000_003C);
    wstrb <= 4'h0;
    wr(OFS_RLD_L, 8'hEE);
    wstrb <= 4'h1;
    lag = 0;
    rdc(OFS_RLD_L, 32'h0000_00C3);
  endtask : t_reset

  task automatic t_mode16;
    wr(OFS_CLKCTL, 8'h05);
    cfg(8'hFE, 8'hFF, 8'h34, 8'h12);
    wr(OFS_CTRL, 8'h04);
    repeat (10) @(posedge mclk);
    chk_irq(1'b1);
    rdc(OFS_CNT_H, 32'h0000_0012);
    rd(OFS_CNT_L);
    chk_rng(rd_v[7:0], 8'h34, 8'h50);
    repeat (50) @(posedge mclk);
    rd(OFS_CTRL);
    chk(rd_v & 32'h0000_00BF, 32'h0000_0084);
    wr(OFS_CTRL, 8'h00);
    chk_irq(1'b0);
  endtask : t_mode16

  task automatic t_low_irq;
    cfg(8'hF0, 8'h00, 8'h00, 8'h00);
    wr(OFS_CTRL, 8'h24);
    repeat (40) @(posedge mclk);
    chk_irq(1'b1);
    rdc(OFS_CTRL, 32'h0000_0064);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CNT_L, 8'hF0);
    wr(OFS_CTRL, 8'h04);
    repeat (40) @(posedge mclk);
    chk_irq(1'b0);
    rdc(OFS_CTRL, 32'h0000_0044);
    wr(OFS_CTRL, 8'h00);
  endtask : t_low_irq

  task automatic t_split;
    wr(OFS_CLKCTL, 8'h07);
    cfg(8'hF0, 8'h55, 8'hF0, 8'h00);
    wr(OFS_CTRL, 8'h08);
    repeat (40) @(posedge mclk);
    rdc(OFS_CNT_H, 32'h0000_0055);
    rd(OFS_CNT_L);
    chk_rng(rd_v[7:0], 8'hF0, 8'hFF);
    rdc(OFS_CTRL, 32'h0000_0048);
    chk_irq(1'b0);
    wr(OFS_CTRL, 8'h68);
    chk_irq(1'b1);
    cfg(8'hF0, 8'hFE, 8'hF0, 8'hA0);
    wr(OFS_CTRL, 8'h0C);
    repeat (4) @(posedge mclk);
    rd(OFS_CTRL);
    chk(rd_v & 32'h0000_0080, 32'h0000_0080);
    chk_irq(1'b1);
    wr(OFS_CTRL, 8'h88);
    rd(OFS_CNT_H);
    chk_rng(rd_v[7:0], 8'hA0, 8'hBF);
    wr(OFS_CTRL, 8'h00);
    chk_irq(1'b0);
  endtask : t_split

  task automatic t_prescale;
    wr(OFS_CLKCTL, 8'h04);
    cfg(8'h00, 8'h00, 8'h00, 8'h00);
    wr(OFS_CTRL, 8'h04);
    repeat (240) @(posedge mclk);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_CNT_L);
    chk_rng(rd_v[7:0], 8'h13, 8'h16);
    wr(OFS_CNT_L, 8'h00);
    wr(OFS_CTRL, 8'h05);
    repeat (64)
    begin
      ext_osc <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_osc <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (8) @(posedge mclk);
    wr(OFS_CTRL, 8'h01);
    rdc(OFS_CNT_L, 32'h0000_0008);
  endtask : t_prescale

  task automatic t_capture;
    wr(OFS_CTRL, 8'h00);
    cfg(8'h5A, 8'hC3, 8'h00, 8'h00);
    wr(OFS_CTRL, 8'h10);
    pulse(1'b1);
    rdc(OFS_RLD_L, 32'h0000_0000);
    chk_irq(1'b0);
    pulse(1'b0);
    rdc(OFS_RLD_L, 32'h0000_005A);
    rdc(OFS_RLD_H, 32'h0000_00C3);
    rdc(OFS_CTRL, 32'h0000_0090);
    chk_irq(1'b1);
    wr(OFS_CTRL, 8'h12);
    wr(OFS_CNT_L, 8'h77);
    pulse(1'b0);
    rdc(OFS_RLD_L, 32'h0000_005A);
    slow_osc <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(OFS_CNT_L, 8'h11);
    repeat (6) @(posedge mclk);
    slow_osc <= 1'b0;
    rdc(OFS_RLD_L, 32'h0000_0077);
    chk_irq(1'b1);
    wr(OFS_CTRL, 8'h19);
    cfg(8'h21, 8'h43, 8'h00, 8'h00);
    pulse(1'b0);
    rdc(OFS_RLD_L, 32'h0000_0021);
    rdc(OFS_RLD_H, 32'h0000_0043);
    chk_irq(1'b1);
  endtask : t_capture

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_mode16();
    t_low_irq();
    t_split();
    t_prescale();
    t_capture();
    end_of_test();
  end

  initial
  begin
    repeat (10000) @(posedge mclk);
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_of_test();
  end

endmodule : tmr3_top_tb

`default_nettype wire
